//--- include/msm_pkg.sv
/*
  Package for the meter settings menu: register map, field encodings,
  menu states and timing counts.
  Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
package msm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ENTER_HOLD_S = 5;
  localparam int unsigned ACCEPT_HOLD_S = 3;
  localparam int unsigned SECS_PER_MIN = 60;
  localparam int unsigned SUB_PERIODS = 15;

  // ---------------------------------------------------------------
  // setting limits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CT_MIN = 8'h01;      // units of 10 A
  localparam logic [7:0] CT_MAX = 8'hC8;      // 200 x 10 A = 2000 A
  localparam logic [7:0] CT_RST = 8'h0A;
  localparam logic [2:0] SCALE_MAX = 3'h4;    // 0:0.1 .. 4:1000.0
  localparam logic [2:0] SCALE_RST = 3'h1;
  localparam logic [1:0] PULSE_MAX = 2'h3;    // 0:1 .. 3:1000
  localparam logic [1:0] PULSE_RST = 2'h0;
  localparam logic [5:0] PERIOD_MIN = 6'h01;
  localparam logic [5:0] PERIOD_MAX = 6'h3C;
  localparam logic [5:0] PERIOD_RST = 6'h0F;
  localparam logic [1:0] BAUD_MAX = 2'h2;     // 0:4800 1:9600 2:19200
  localparam logic [1:0] BAUD_RST = 2'h1;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_RST = 8'h01;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SET0 = 8'h08;
  localparam logic [7:0] OFS_SET1 = 8'h0C;
  localparam logic [7:0] OFS_DEMAND = 8'h10;
  localparam logic [7:0] OFS_REQ = 8'h14;
  localparam int unsigned CTRL_OPT_BIT = 0;
  localparam int unsigned CTRL_APPLY_BIT = 1;

  typedef enum logic [2:0] {
    MI_CT, MI_SCALE, MI_PULSE, MI_PERIOD, MI_BAUD, MI_ADDR
  } msm_item_t;

  typedef struct packed {
    logic [7:0] ct;
    logic [2:0] scale;
    logic [1:0] pulse;
    logic [5:0] period;
    logic [1:0] baud;
    logic [7:0] addr;
  } msm_settings_t;

  localparam msm_settings_t SET_RST = '{CT_RST, SCALE_RST, PULSE_RST, PERIOD_RST,
                                        BAUD_RST, ADDR_RST};

endpackage

//--- hdl/msm_hold_timer.sv
/*
  Hold timer: counts cycles while both keys are down and pulses once
  when the hold reaches the given count.
  Assumes key levels are already synchronised to clk_i.
*/
`timescale 1ns/1ps
module msm_hold_timer import msm_pkg::*; #(
  parameter int unsigned COUNT = 1000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic both_i,
  output logic fire_o
);
  logic [31:0] cnt_r;
  wire logic reached = (cnt_r == 32'(COUNT - 1));

  // fires once per hold; counter parks until the keys are released
  always_ff @(posedge clk_i) begin
    if (srst_i || !both_i) begin
      cnt_r <= '0;
    end else if (cnt_r != 32'(COUNT)) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  assign fire_o = both_i && reached;
endmodule

//--- hdl/msm_demand_avg.sv
/*
  Rolling demand: ring of sub-period averages and their running mean.
  Assumes sub-period averages arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
module msm_demand_avg import msm_pkg::*; (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sub_vld_i,
  input wire logic [31:0] sub_avg_i,
  output logic [31:0] demand_o
);
  logic [31:0] ring_r [SUB_PERIODS];
  logic [3:0] wp_r;
  logic [35:0] sum_r;
  wire logic [3:0] wp_nxt = (wp_r == 4'(SUB_PERIODS - 1)) ? 4'h0 : wp_r + 4'h1;

  // newest value replaces oldest; running sum avoids a 15-way adder
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SUB_PERIODS; i++) ring_r[i] <= '0;
      wp_r <= '0;
      sum_r <= '0;
      demand_o <= '0;
    end else if (sub_vld_i) begin
      ring_r[wp_r] <= sub_avg_i;
      wp_r <= wp_nxt;
      sum_r <= sum_r + 36'(sub_avg_i) - 36'(ring_r[wp_r]);
      demand_o <= 32'((sum_r + 36'(sub_avg_i) - 36'(ring_r[wp_r])) / 36'(SUB_PERIODS));
    end
  end
endmodule

//--- hdl/msm_menu.sv
/*
  Settings menu for the energy meter: key-driven editing of the stored
  settings, the one-second link to the options module, pulse output
  division and rolling demand.
  Assumes raw key pins, a one-cycle second tick from the measurement
  timing, and an APB master for status and settings access.
*/
// Function
// R1 - both keys held 5 s enters the menu
// R2 - measurement keeps running while menu is active
// R3 - items in fixed order ct, scale, pulse, period, baud, address
// R4 - ct 10 A to 2000 A in 10 A steps, multiplies measurements
// R5 - ct item: up adds 10 A, down subtracts 10 A
// R6 - both keys held 3 s accepts and advances
// R7 - scale one of five decades 0.1 to 1000.0, multiplies measurements
// R8 - scale item: up times ten, down divide by ten
// R9 - pulse every 1, 10, 100 or 1000 accumulator increments
// R10 - pulse item: up next larger decade, down next smaller
// R11 - demand period 1 to 60 minutes, one minute per press
// R12 - baud item offers 4800, 9600, 19200, up higher, down lower
// R13 - address 1 to 247, up increments, down decrements
// R14 - baud and address shown only when options module detected
// R15 - link starts itself, sends readings and settings every second
// R16 - options module confirms and may request setting changes
// R17 - options module drives its own link-ok lamp
// R18 - options module maps power and demand to 4-20 mA
// R19 - power output per second, demand output per sub-period
// R20 - options module holds outputs at 4 mA with no meter
// R21 - demand is mean of 15 rolling sub-period averages
// R22 - limits saturate, no wrap
// R23 - accepted settings stored and sent in next transfer
`timescale 1ns/1ps
module msm_menu import msm_pkg::*; #(
  parameter int unsigned ENTER_CYC = ENTER_HOLD_S * CLK_HZ,
  parameter int unsigned ACCEPT_CYC = ACCEPT_HOLD_S * CLK_HZ
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic key_up_i,
  input wire logic key_dn_i,
  input wire logic sec_tick_i,
  input wire logic [31:0] raw_power_i,
  input wire logic energy_inc_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic menu_active_o,
  output logic [2:0] menu_item_o,
  output logic [31:0] scaled_power_o,
  output logic pulse_o,
  output logic link_send_o,
  output msm_settings_t link_set_o,
  output logic [31:0] link_power_o,
  output logic nv_store_o,
  output msm_settings_t nv_data_o,
  output logic sub_tick_o,
  output logic [31:0] rolling_demand_o
);
  // ---------------------------------------------------------------
  // key synchronisers and press edges
  // ---------------------------------------------------------------
  logic [1:0] up_s_r, dn_s_r;
  logic up_d_r, dn_d_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      up_s_r <= '0;
      dn_s_r <= '0;
      up_d_r <= 1'b0;
      dn_d_r <= 1'b0;
    end else begin
      up_s_r <= {up_s_r[0], key_up_i};
      dn_s_r <= {dn_s_r[0], key_dn_i};
      up_d_r <= up_s_r[1];
      dn_d_r <= dn_s_r[1];
    end
  end
  wire logic up = up_s_r[1];
  wire logic dn = dn_s_r[1];
  wire logic both = up && dn;
  // a single press acts on release so the start of a two-key hold edits nothing
  logic lone_up_r, lone_dn_r;
  wire logic up_press = up_d_r && !up && lone_up_r;
  wire logic dn_press = dn_d_r && !dn && lone_dn_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lone_up_r <= 1'b0;
      lone_dn_r <= 1'b0;
    end else begin
      lone_up_r <= up ? (lone_up_r || !up_d_r) && !dn : 1'b0;
      lone_dn_r <= dn ? (lone_dn_r || !dn_d_r) && !up : 1'b0;
    end
  end

  logic enter_fire, accept_fire;
  msm_hold_timer #(.COUNT(ENTER_CYC)) u_enter (
    .clk_i(clk_i), .srst_i(srst_i), .both_i(both && !menu_active_o), .fire_o(enter_fire)
  );
  msm_hold_timer #(.COUNT(ACCEPT_CYC)) u_accept (
    .clk_i(clk_i), .srst_i(srst_i), .both_i(both && menu_active_o), .fire_o(accept_fire)
  );

  // ---------------------------------------------------------------
  // step helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] step8(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic u, input logic d);
    if (u && v < hi) return v + 8'h1;   // see R22
    if (d && v > lo) return v - 8'h1;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // menu state and settings
  // ---------------------------------------------------------------
  logic opt_present_r;
  msm_settings_t set_r, edit_r, edit_nxt;
  msm_item_t item_r;
  wire logic last_item = opt_present_r ? (item_r == MI_ADDR) : (item_r == MI_PERIOD);
  wire msm_item_t item_next = msm_item_t'(3'(item_r) + 3'h1);
  logic apply_req_r;
  msm_settings_t req_r;

  always_comb begin
    edit_nxt = edit_r;
    case (item_r)
      MI_CT: edit_nxt.ct = step8(edit_r.ct, CT_MIN, CT_MAX, up_press, dn_press); // see R5
      MI_SCALE: edit_nxt.scale = 3'(step8(8'(edit_r.scale), 8'h0, 8'(SCALE_MAX),
                                           up_press, dn_press));       // see R8
      MI_PULSE: edit_nxt.pulse = 2'(step8(8'(edit_r.pulse), 8'h0, 8'(PULSE_MAX),
                                           up_press, dn_press));       // see R10
      MI_PERIOD: edit_nxt.period = 6'(step8(8'(edit_r.period), 8'(PERIOD_MIN),
                                             8'(PERIOD_MAX), up_press, dn_press)); // see R11
      MI_BAUD: edit_nxt.baud = 2'(step8(8'(edit_r.baud), 8'h0, 8'(BAUD_MAX),
                                         up_press, dn_press));         // see R12
      MI_ADDR: edit_nxt.addr = step8(edit_r.addr, ADDR_MIN, ADDR_MAX, up_press,
                                     dn_press);                        // see R13
      default: edit_nxt = edit_r;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      menu_active_o <= 1'b0;
      item_r <= MI_CT;
      set_r <= SET_RST;
      edit_r <= SET_RST;
    end else if (!menu_active_o) begin
      if (enter_fire) begin                    // see R1
        menu_active_o <= 1'b1;
        item_r <= MI_CT;                       // see R3
        edit_r <= set_r;
      end else if (apply_req_r) begin          // see R16
        set_r <= req_r;
      end
    end else if (accept_fire) begin            // see R6
      set_r <= edit_r;                         // see R23
      if (last_item) begin                     // see R14
        menu_active_o <= 1'b0;
      end else begin
        item_r <= item_next;                   // see R3
      end
    end else begin
      edit_r <= edit_nxt;
    end
  end
  assign menu_item_o = 3'(item_r);

  // nv write on every accept
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nv_store_o <= 1'b0;
      nv_data_o <= SET_RST;
    end else begin
      nv_store_o <= menu_active_o && accept_fire;   // see R23
      nv_data_o <= edit_r;
    end
  end

  // ---------------------------------------------------------------
  // measurement scaling (runs regardless of menu)
  // ---------------------------------------------------------------
  // ct*10 A then scale decade; 0.1 applied as divide by ten
  wire logic [47:0] ct_prod = 48'(raw_power_i) * 48'(set_r.ct) * 48'h0A; // see R4
  logic [47:0] scaled;
  always_comb begin
    case (set_r.scale)                         // see R7
      3'h0: scaled = ct_prod / 48'h0A;
      3'h1: scaled = ct_prod;
      3'h2: scaled = 48'(ct_prod * 48'h0A);
      3'h3: scaled = 48'(ct_prod * 48'h64);
      default: scaled = 48'(ct_prod * 48'h3E8);
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) scaled_power_o <= '0;
    else if (sec_tick_i) scaled_power_o <= scaled[31:0];  // see R2
  end

  // ---------------------------------------------------------------
  // pulse output divider
  // ---------------------------------------------------------------
  logic [9:0] pcnt_r;
  wire logic [9:0] pdiv = (set_r.pulse == 2'h0) ? 10'h001 : (set_r.pulse == 2'h1) ? 10'h00A :
                          (set_r.pulse == 2'h2) ? 10'h064 : 10'h3E8;
  wire logic pwrap = (pcnt_r + 10'h1 >= pdiv);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pcnt_r <= '0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= energy_inc_i && pwrap;        // see R9
      if (energy_inc_i) pcnt_r <= pwrap ? 10'h0 : pcnt_r + 10'h1;
    end
  end

  // ---------------------------------------------------------------
  // sub-period timing and rolling demand
  // ---------------------------------------------------------------
  logic [7:0] sec_cnt_r;
  logic [39:0] acc_r;
  logic [7:0] nacc_r;
  wire logic [7:0] sub_len = 8'((16'(set_r.period) * 16'(SECS_PER_MIN)) / 16'(SUB_PERIODS));
  wire logic sub_end = sec_tick_i && (sec_cnt_r + 8'h1 >= sub_len);
  logic sub_vld_r;
  logic [31:0] sub_avg_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sec_cnt_r <= '0;
      acc_r <= '0;
      nacc_r <= '0;
      sub_vld_r <= 1'b0;
      sub_avg_r <= '0;
    end else begin
      sub_vld_r <= sub_end;
      if (sub_end) begin
        sub_avg_r <= 32'((acc_r + 40'(scaled[31:0])) / 40'(nacc_r + 8'h1));
        sec_cnt_r <= '0;
        acc_r <= '0;
        nacc_r <= '0;
      end else if (sec_tick_i) begin
        sec_cnt_r <= sec_cnt_r + 8'h1;
        acc_r <= acc_r + 40'(scaled[31:0]);
        nacc_r <= nacc_r + 8'h1;
      end
    end
  end
  assign sub_tick_o = sub_vld_r;               // see R19

  msm_demand_avg u_demand (                    // see R21
    .clk_i(clk_i), .srst_i(srst_i), .sub_vld_i(sub_vld_r),
    .sub_avg_i(sub_avg_r), .demand_o(rolling_demand_o)
  );

  // ---------------------------------------------------------------
  // one-second link transfer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link_send_o <= 1'b0;
      link_set_o <= SET_RST;
      link_power_o <= '0;
    end else begin
      link_send_o <= sec_tick_i;               // see R15
      if (sec_tick_i) begin
        link_set_o <= set_r;                   // see R23
        link_power_o <= scaled[31:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  wire logic wr_en = psel && penable && pwrite;
  wire logic known = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_SET0) ||
                     (paddr == OFS_SET1) || (paddr == OFS_DEMAND) || (paddr == OFS_REQ);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      opt_present_r <= 1'b0;
      apply_req_r <= 1'b0;
      req_r <= SET_RST;
    end else begin
      apply_req_r <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_APPLY_BIT];
      if (wr_en && paddr == OFS_CTRL) opt_present_r <= pwdata[CTRL_OPT_BIT]; // see R14
      if (wr_en && paddr == OFS_REQ) req_r <= msm_settings_t'(pwdata[28:0]);
    end
  end
  wire logic [31:0] rd_mux =
    (paddr == OFS_CTRL) ? {31'h0, opt_present_r} :
    (paddr == OFS_STATUS) ? {28'h0, menu_item_o, menu_active_o} :
    (paddr == OFS_SET0) ? {3'h0, set_r} :
    (paddr == OFS_SET1) ? {3'h0, edit_r} :
    (paddr == OFS_DEMAND) ? rolling_demand_o :
    (paddr == OFS_REQ) ? {3'h0, req_r} : 32'h0;
  always_ff @(posedge clk_i) begin
    if (srst_i) prdata <= '0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ct_range;
    @(posedge clk_i) disable iff (srst_i) set_r.ct >= CT_MIN && set_r.ct <= CT_MAX;
  endproperty
  a_ct_range: assert property (p_ct_range) else $error("ct out of range"); // see R4
  property p_enter;
    @(posedge clk_i) disable iff (srst_i) $rose(menu_active_o) |-> $past(enter_fire);
  endproperty
  a_enter: assert property (p_enter) else $error("menu entered without hold"); // see R1
  property p_accept_adv;
    @(posedge clk_i) disable iff (srst_i)
      menu_active_o && accept_fire && !last_item |=> item_r == $past(item_next);
  endproperty
  a_accept_adv: assert property (p_accept_adv) else $error("accept did not advance"); // see R6
  property p_skip_opt;
    @(posedge clk_i) disable iff (srst_i) !opt_present_r && menu_active_o |-> item_r <= MI_PERIOD;
  endproperty
  a_skip_opt: assert property (p_skip_opt) else $error("comm item without module"); // see R14
  property p_period_range;
    @(posedge clk_i) disable iff (srst_i) edit_r.period >= PERIOD_MIN && edit_r.period <= PERIOD_MAX;
  endproperty
  a_period_range: assert property (p_period_range) else $error("period out of range"); // see R11
  property p_addr_range;
    @(posedge clk_i) disable iff (srst_i) edit_r.addr >= ADDR_MIN && edit_r.addr <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range"); // see R13
  property p_link;
    @(posedge clk_i) disable iff (srst_i) sec_tick_i |=> link_send_o && link_set_o == $past(set_r);
  endproperty
  a_link: assert property (p_link) else $error("link transfer missed"); // see R15
  property p_nv;
    @(posedge clk_i) disable iff (srst_i) menu_active_o && accept_fire |=> nv_store_o ##1 !nv_store_o;
  endproperty
  a_nv: assert property (p_nv) else $error("accept not stored"); // see R23
  property p_scale_step;
    @(posedge clk_i) disable iff (srst_i) menu_active_o && !accept_fire && item_r == MI_SCALE &&
      up_press && edit_r.scale < SCALE_MAX |=> edit_r.scale == $past(edit_r.scale) + 3'h1;
  endproperty
  a_scale_step: assert property (p_scale_step) else $error("scale step wrong"); // see R8
  c_enter: cover property (@(posedge clk_i) $rose(menu_active_o));
  c_exit: cover property (@(posedge clk_i) $fell(menu_active_o));
  c_pulse: cover property (@(posedge clk_i) pulse_o);
  c_sub: cover property (@(posedge clk_i) sub_tick_o);
endmodule

//--- test/msm_opt_model.sv
/*
  Options module model: takes each one-second frame from the meter,
  echoes the settings back and keeps a link-ok lamp.
  Assumes link_send_i is a one-cycle strobe on clk_i.
*/
`timescale 1ns/1ps
module msm_opt_model import msm_pkg::*; #(
  parameter int unsigned LOST_CYC = 400
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic link_send_i,
  input wire msm_settings_t link_set_i,
  input wire logic [31:0] link_power_i,
  input wire logic sub_tick_i,
  input wire logic [31:0] demand_i,
  output logic link_ok_o,
  output msm_settings_t echo_o,
  output logic [15:0] ao_pwr_o,
  output logic [15:0] ao_avg_o
);
  // ---------------------------------------------------------------
  // analogue outputs: code 0 is 4 mA, 16'hFFFF is 20 mA
  // ---------------------------------------------------------------
  // limitation: full scale fixed at 16 bits of counts, above it saturates
  logic [15:0] ao_pwr_r, ao_avg_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ao_pwr_r <= 16'h0000;
      ao_avg_r <= 16'h0000;
    end else begin
      if (link_send_i) ao_pwr_r <= (|link_power_i[31:16]) ? 16'hFFFF : link_power_i[15:0];
      if (sub_tick_i) ao_avg_r <= (|demand_i[31:16]) ? 16'hFFFF : demand_i[15:0];
    end
  end
  assign ao_pwr_o = link_ok_o ? ao_pwr_r : 16'h0000;
  assign ao_avg_o = link_ok_o ? ao_avg_r : 16'h0000;
  // ---------------------------------------------------------------
  // frame capture and lamp
  // ---------------------------------------------------------------
  logic [15:0] quiet_r;
  logic seen_r;
  // lamp drops once frames stop for longer than LOST_CYC
  assign link_ok_o = seen_r && (quiet_r < 16'(LOST_CYC));
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      quiet_r <= 16'h0000;
      seen_r <= 1'b0;
      echo_o <= '0;
    end else if (link_send_i) begin
      quiet_r <= 16'h0000;
      seen_r <= 1'b1;
      echo_o <= link_set_i;
    end else if (quiet_r != 16'hFFFF) begin
      quiet_r <= quiet_r + 16'h0001;
    end
  end
endmodule

//--- test/meter_settings_menu_bench.sv
/*
  Testbench for the settings menu: keys, second tick, energy strobe
  and APB register access, checked against the stored settings.
  Assumes short hold counts (20 and 12 cycles) in place of seconds.
*/
`timescale 1ns/1ps
module meter_settings_menu_bench import msm_pkg::*;;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic key_up_i = 1'b0;
  logic key_dn_i = 1'b0;
  logic sec_tick_i = 1'b0;
  logic energy_inc_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] raw_power_i = 32'h0000_0064;
  logic [31:0] prdata, scaled_power_o, link_power_o, rolling_demand_o, rd;
  logic pready, pslverr, menu_active_o, pulse_o, link_send_o, nv_store_o;
  logic sub_tick_o, err, link_ok;
  logic [2:0] menu_item_o;
  logic [15:0] ao_pwr, ao_avg;
  msm_settings_t link_set_o, nv_data_o, echo, exp_set, stored, ed;
  int bad_count = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;
  int sub_cnt = 0;
  int held, base;

  msm_menu #(.ENTER_CYC(20), .ACCEPT_CYC(12)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
    .key_up_i(key_up_i), .key_dn_i(key_dn_i), .sec_tick_i(sec_tick_i),
    .raw_power_i(raw_power_i), .energy_inc_i(energy_inc_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .menu_active_o(menu_active_o),
    .menu_item_o(menu_item_o), .scaled_power_o(scaled_power_o), .pulse_o(pulse_o),
    .link_send_o(link_send_o), .link_set_o(link_set_o), .link_power_o(link_power_o),
    .nv_store_o(nv_store_o), .nv_data_o(nv_data_o), .sub_tick_o(sub_tick_o),
    .rolling_demand_o(rolling_demand_o));
  msm_opt_model i_opt (.clk_i(clk_i), .srst_i(srst_i), .link_send_i(link_send_o),
    .link_set_i(link_set_o), .link_power_i(link_power_o), .sub_tick_i(sub_tick_o),
    .demand_i(rolling_demand_o), .link_ok_o(link_ok), .echo_o(echo), .ao_pwr_o(ao_pwr),
    .ao_avg_o(ao_avg));

  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (pulse_o === 1'b1) pulse_cnt++;
    if (sub_tick_o === 1'b1) sub_cnt++;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic press(input logic up, input int n);
    repeat (n) begin
      @(posedge clk_i);
      key_up_i <= up;
      key_dn_i <= ~up;
      repeat (3) @(posedge clk_i);
      key_up_i <= 1'b0;
      key_dn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask
  // holds both keys until menu entry, an accept strobe or lim cycles
  task automatic hold_both(input int lim);
    logic was;
    @(posedge clk_i);
    key_up_i <= 1'b1;
    key_dn_i <= 1'b1;
    was = menu_active_o;
    held = 0;
    do begin
      @(posedge clk_i);
      held++;
      if (nv_store_o === 1'b1) stored = nv_data_o;
    end while (nv_store_o !== 1'b1 && menu_active_o === was && held < lim);
    key_up_i <= 1'b0;
    key_dn_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic accept(input logic [2:0] item);
    hold_both(40);
    chk("accept time", 32'(held >= 12 && held <= 18), 32'h1);
    chk("stored", 32'(stored), 32'(exp_set));
    chk("item", 32'(menu_item_o), 32'(item));
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      sec_tick_i <= 1'b1;
      @(posedge clk_i);
      sec_tick_i <= 1'b0;
      #1;
      chk("link send", 32'(link_send_o), 32'h1);
      chk("link set", 32'(link_set_o), 32'(exp_set));
      repeat (3) @(posedge clk_i);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
  initial begin
    exp_set = SET_RST;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(1'b0, OFS_SET0, 32'h0000_0000);
    chk("set0 reset", rd, 32'(exp_set));
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'(err), 32'h1);
    chk("ao min", 32'(ao_pwr), 32'h0);
    tick(1);
    chk("ao power", 32'(ao_pwr), 32'h0000_2710);
    chk("echo", 32'(echo), 32'(exp_set));
    chk("link ok", 32'(link_ok), 32'h1);
    hold_both(10);
    chk("short hold", 32'(menu_active_o), 32'h0);
    hold_both(40);
    chk("enter", 32'(menu_active_o), 32'h1);
    chk("enter time", 32'(held >= 20 && held <= 26), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_0001);
    tick(1);
    press(1'b1, 3);
    press(1'b0, 1);
    apb(1'b0, OFS_SET1, 32'h0000_0000);
    ed = rd[28:0];
    chk("edit ct", 32'(ed.ct), 32'h0000_000C);
    exp_set.ct = 8'h0C;
    accept(3'h1);
    press(1'b1, 5);
    exp_set.scale = SCALE_MAX;
    accept(3'h2);
    press(1'b1, 1);
    exp_set.pulse = 2'h1;
    accept(3'h3);
    press(1'b0, 20);
    exp_set.period = PERIOD_MIN;
    accept(3'h3);
    chk("exit no options", 32'(menu_active_o), 32'h0);
    apb(1'b0, OFS_SET0, 32'h0000_0000);
    chk("set0", rd, 32'(exp_set));
    base = pulse_cnt;
    repeat (20) begin
      @(posedge clk_i);
      energy_inc_i <= 1'b1;
      @(posedge clk_i);
      energy_inc_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    chk("pulses", 32'(pulse_cnt - base), 32'h2);
    base = sub_cnt;
    tick(8);
    chk("sub ticks", 32'(sub_cnt - base), 32'h2);
    chk("ao avg", 32'(ao_avg), 32'h0000_FFFF);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    hold_both(40);
    repeat (4) hold_both(40);
    chk("baud item", 32'(menu_item_o), 32'h4);
    press(1'b1, 3);
    exp_set.baud = BAUD_MAX;
    accept(3'h5);
    press(1'b0, 2);
    press(1'b1, 1);
    exp_set.addr = 8'h02;
    accept(3'h5);
    chk("exit", 32'(menu_active_o), 32'h0);
    exp_set.ct = CT_MAX;
    apb(1'b1, OFS_REQ, 32'(exp_set));
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    apb(1'b0, OFS_SET0, 32'h0000_0000);
    chk("applied", rd, 32'(exp_set));
    tick(1);
    close_out();
  end
endmodule
